// file: bsc_pkg.sv
// shared constants, types and helpers for the burst sram cache pair
// ==========================================================
// widths and sizes
// ==========================================================
package bsc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int CNT_W = 2;
  localparam int BURST_LEN = 4;
  localparam int MEM_DEPTH = 65536;
  localparam int LINE_BYTES = 32;
  localparam int LINE_W = DATA_W * BURST_LEN;

  // ==========================================================
  // tag store sizing
  // ==========================================================
  localparam int TAG_DEPTH_ONE_LINE = 16384;
  localparam int CACHE_BYTES = 524288;
  localparam int MAIN_MEM_BYTES = 134217728;
  localparam int TAG_W_DFLT = $clog2(MAIN_MEM_BYTES / CACHE_BYTES);
  localparam int TAG_W_ALT = 10;

  // ==========================================================
  // reset values and encodings
  // ==========================================================
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [1:0] LANES_NONE = 2'h0;

  typedef enum logic [5:0] {
    BSC_IDLE  = 6'h01,
    BSC_WAIT  = 6'h02,
    BSC_START = 6'h04,
    BSC_HOLD  = 6'h08,
    BSC_BEAT  = 6'h10,
    BSC_DRAIN = 6'h20
  } bsc_ctrl_state_t;

  // interleaved order on the two low bits, wrapping inside the line
  function automatic logic [ADDR_W-1:0] burst_addr(
    input logic [ADDR_W-1:0] base,
    input logic [CNT_W-1:0] cnt
  );
    burst_addr = {base[ADDR_W-1:CNT_W], base[CNT_W-1:0] ^ cnt};
  endfunction

  function automatic int tag_depth(input int lines_per_sector);
    tag_depth = TAG_DEPTH_ONE_LINE / lines_per_sector;
  endfunction

endpackage

// file: bsc_if.sv
// pin-level link between cache controller and burst sram
`timescale 1ns/1ps
`default_nettype none
interface bsc_if;
  logic [bsc_pkg::ADDR_W-1:0] addr;
  logic proc_addr_strobe_n;
  logic ctrl_addr_strobe_n;
  logic burst_advance_n;
  logic chip_en_n;
  logic low_byte_write_n;
  logic high_byte_write_n;
  logic [bsc_pkg::DATA_W-1:0] dq_host_o;
  logic dq_host_oe;
  logic [bsc_pkg::DATA_W-1:0] dq_dev_o;
  logic dq_dev_oe;
  logic [bsc_pkg::DATA_W-1:0] dq_bus;

  // resolved data wire; device wins if both drive (a contention bug)
  assign dq_bus = dq_dev_oe ? dq_dev_o : (dq_host_oe ? dq_host_o : '0);

  modport dev (
    input addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
    input chip_en_n, low_byte_write_n, high_byte_write_n, dq_bus,
    output dq_dev_o, dq_dev_oe
  );

  modport host (
    output addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
    output chip_en_n, low_byte_write_n, high_byte_write_n,
    output dq_host_o, dq_host_oe,
    input dq_bus
  );
endinterface
`default_nettype wire

// file: bsc_sram_dev.sv
// synchronous burst sram end: registered inputs, burst counter, self-timed write
`timescale 1ns/1ps
`default_nettype none
module bsc_sram_dev #(
  parameter int DEPTH = bsc_pkg::MEM_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link to the cache controller
  bsc_if.dev bus,
  // local side
  input wire logic out_en_n,
  output logic burst_active,
  output logic [bsc_pkg::CNT_W-1:0] beat_index
);

  localparam int IDX_W = $clog2(DEPTH);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  generate
    if (DEPTH < bsc_pkg::BURST_LEN || DEPTH > bsc_pkg::MEM_DEPTH || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("bsc_sram_dev: DEPTH must be a power of two within the address space");
    end
  endgenerate

  // ==========================================================
  // storage and state
  // ==========================================================
  logic [bsc_pkg::DATA_W-1:0] mem [DEPTH];

  logic [bsc_pkg::ADDR_W-1:0] base_r;
  logic [bsc_pkg::CNT_W-1:0] cnt_r;
  logic live_r;
  logic hold_r;

  // write pipeline: one register stage between the pins and the array
  logic wr_pend_r;
  logic [1:0] wr_lanes_r;
  logic [bsc_pkg::ADDR_W-1:0] wr_addr_r;
  logic [bsc_pkg::DATA_W-1:0] wr_data_r;

  // read register, drives the data lines for one cycle
  logic [bsc_pkg::DATA_W-1:0] rd_data_r;
  logic rd_valid_r;

  // ==========================================================
  // decode of the sampled pins
  // ==========================================================
  logic proc_go;
  logic ctrl_go;
  logic step;
  logic op;
  logic wr_req;
  logic [1:0] lanes;
  logic [bsc_pkg::CNT_W-1:0] cnt_nxt;
  logic lanes_any;
  logic [bsc_pkg::ADDR_W-1:0] eff_addr;

  // pins are read through these terms, which flops consume, except lanes_any, which also gates the data driver directly
  always_comb
  begin
    proc_go = ~bus.proc_addr_strobe_n;
    // processor strobe takes precedence when both are low
    ctrl_go = ~bus.ctrl_addr_strobe_n & ~proc_go;
    lanes = {~bus.high_byte_write_n, ~bus.low_byte_write_n};
    lanes_any = lanes != bsc_pkg::LANES_NONE;
    // a write after a processor start holds beat 0 whatever advance says;
    // a read there must step at once or it would repeat its first word
    step = live_r & ~proc_go & ~ctrl_go & ~bus.burst_advance_n & ~(hold_r & lanes_any);
    cnt_nxt = step ? cnt_r + 2'h1 : cnt_r;
    if (proc_go || ctrl_go)
    begin
      eff_addr = bus.addr;
      op = ~bus.chip_en_n;
    end
    else
    begin
      eff_addr = bsc_pkg::burst_addr(base_r, cnt_nxt);
      op = live_r & (hold_r | step);
    end
    // write register blocked during a processor strobe
    wr_req = op & ~proc_go & lanes_any;
  end

  // ==========================================================
  // burst tracking
  // ==========================================================
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      base_r <= bsc_pkg::ADDR_RST;
      cnt_r <= bsc_pkg::CNT_RST;
      live_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else if (proc_go || ctrl_go)
    begin
      base_r <= bus.addr;
      cnt_r <= bsc_pkg::CNT_RST;
      live_r <= ~bus.chip_en_n;
      hold_r <= proc_go & ~bus.chip_en_n;
    end
    else
    begin
      hold_r <= 1'b0;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // self-timed write: strobes, address and data are registered,
  // the array is written on the following edge, so the master
  // never has to shape a write pulse
  // ==========================================================
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_r <= 1'b0;
      wr_lanes_r <= bsc_pkg::LANES_NONE;
      wr_addr_r <= bsc_pkg::ADDR_RST;
      wr_data_r <= bsc_pkg::DATA_RST;
    end
    else
    begin
      wr_pend_r <= wr_req;
      wr_lanes_r <= lanes;
      wr_addr_r <= eff_addr;
      wr_data_r <= bus.dq_bus;
    end
  end

  // array content has no reset, as in the real part
  always_ff @(posedge mclk)
  begin
    if (wr_pend_r)
    begin
      if (wr_lanes_r[0])
      begin
        mem[wr_addr_r[IDX_W-1:0]][bsc_pkg::LANE_W-1:0] <= wr_data_r[bsc_pkg::LANE_W-1:0];
      end
      if (wr_lanes_r[1])
      begin
        mem[wr_addr_r[IDX_W-1:0]][bsc_pkg::DATA_W-1:bsc_pkg::LANE_W] <=
          wr_data_r[bsc_pkg::DATA_W-1:bsc_pkg::LANE_W];
      end
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  // limitation: a read of the word written on the previous edge returns old data
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r <= bsc_pkg::DATA_RST;
    end
    else
    begin
      rd_valid_r <= op & ~wr_req;
      if (op && !wr_req)
      begin
        rd_data_r <= mem[eff_addr[IDX_W-1:0]];
      end
    end
  end

  // ==========================================================
  // data drivers
  // ==========================================================
  // output enable is asynchronous, so it gates the driver directly;
  // a beat with a lane strobe low belongs to the writer, which keeps
  // the read begun by a processor strobe off the first write word
  assign bus.dq_dev_o = rd_data_r;
  assign bus.dq_dev_oe = rd_valid_r & ~out_en_n & ~lanes_any;

  // ==========================================================
  // status outputs
  // ==========================================================
  assign burst_active = live_r;
  assign beat_index = cnt_r;

endmodule // bsc_sram_dev
`default_nettype wire

// file: bsc_cache_ctrl.sv
// cache controller end: line bursts to the sram plus direct-mapped tag store
`timescale 1ns/1ps
`default_nettype none
module bsc_cache_ctrl #(
  parameter int LINES_PER_SECTOR = 1,
  parameter int TAG_W = bsc_pkg::TAG_W_DFLT,
  parameter bit SLOW_TAG = 1'b0,
  parameter bit START_BY_PROC = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link to the sram
  bsc_if.host bus,
  // line request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [bsc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_lanes,
  input wire logic [bsc_pkg::LINE_W-1:0] req_wline,
  input wire logic [TAG_W-1:0] req_tag,
  // answer
  output logic [bsc_pkg::LINE_W-1:0] rd_line,
  output logic rd_valid,
  output logic tag_hit
);

  localparam int TAG_DEPTH = bsc_pkg::tag_depth(LINES_PER_SECTOR);
  localparam int TIDX_W = $clog2(TAG_DEPTH);
  localparam int SHIFT = $clog2(LINES_PER_SECTOR);
  localparam int DW = bsc_pkg::DATA_W;

  // ==========================================================
  // elaboration checks
  // ==========================================================
  generate
    if (LINES_PER_SECTOR != 1 && LINES_PER_SECTOR != 2 && LINES_PER_SECTOR != 4)
    begin : g_bad_lines
      $error("bsc_cache_ctrl: LINES_PER_SECTOR must be 1, 2 or 4");
    end
    if (TAG_W != bsc_pkg::TAG_W_DFLT && TAG_W != bsc_pkg::TAG_W_ALT)
    begin : g_bad_tag
      $error("bsc_cache_ctrl: TAG_W must be 8 or 10");
    end
  endgenerate

  // ==========================================================
  // tag store, sized by lines per sector
  // ==========================================================
  logic [TAG_W-1:0] tags [TAG_DEPTH];
  logic [bsc_pkg::ADDR_W-1:0] line_addr;
  logic [TIDX_W-1:0] tag_idx;

  always_comb
  begin
    line_addr = req_addr >> bsc_pkg::CNT_W;
    tag_idx = line_addr[SHIFT +: TIDX_W];
  end

  always_ff @(posedge mclk)
  begin
    if (req_valid && req_ready && req_write)
    begin
      tags[tag_idx] <= req_tag;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tag_hit <= 1'b0;
    end
    else if (req_valid && req_ready)
    begin
      tag_hit <= tags[tag_idx] == req_tag;
    end
  end

  // ==========================================================
  // burst sequencer
  // ==========================================================
  bsc_pkg::bsc_ctrl_state_t st_r;
  logic [bsc_pkg::CNT_W-1:0] beat_r;
  logic [bsc_pkg::ADDR_W-1:0] addr_r;
  logic we_r;
  logic [1:0] lanes_r;
  logic [bsc_pkg::LINE_W-1:0] line_r;
  logic [DW-1:0] dq_r;

  assign req_ready = st_r == bsc_pkg::BSC_IDLE;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= bsc_pkg::BSC_IDLE;
      beat_r <= bsc_pkg::CNT_RST;
      addr_r <= bsc_pkg::ADDR_RST;
      we_r <= 1'b0;
      lanes_r <= bsc_pkg::LANES_NONE;
      line_r <= '0;
      dq_r <= bsc_pkg::DATA_RST;
    end
    else
    begin
      unique case (st_r)
        bsc_pkg::BSC_IDLE:
        begin
          beat_r <= bsc_pkg::CNT_RST;
          if (req_valid)
          begin
            addr_r <= req_addr;
            we_r <= req_write;
            lanes_r <= req_lanes;
            line_r <= req_wline;
            dq_r <= req_wline[DW-1:0];
            // slow tag compare costs one lead-off cycle
            st_r <= SLOW_TAG ? bsc_pkg::BSC_WAIT : bsc_pkg::BSC_START;
          end
        end
        bsc_pkg::BSC_WAIT:
        begin
          st_r <= bsc_pkg::BSC_START;
        end
        bsc_pkg::BSC_START:
        begin
          if (we_r && START_BY_PROC)
          begin
            st_r <= bsc_pkg::BSC_HOLD;
          end
          else
          begin
            beat_r <= 2'h1;
            dq_r <= line_r[DW +: DW];
            st_r <= bsc_pkg::BSC_BEAT;
          end
        end
        bsc_pkg::BSC_HOLD:
        begin
          beat_r <= 2'h1;
          dq_r <= line_r[DW +: DW];
          st_r <= bsc_pkg::BSC_BEAT;
        end
        bsc_pkg::BSC_BEAT:
        begin
          beat_r <= beat_r + 2'h1;
          dq_r <= line_r[DW * 32'(2'(beat_r + 2'h1)) +: DW];
          if (beat_r == 2'h3)
          begin
            st_r <= we_r ? bsc_pkg::BSC_IDLE : bsc_pkg::BSC_DRAIN;
          end
        end
        bsc_pkg::BSC_DRAIN:
        begin
          st_r <= bsc_pkg::BSC_IDLE;
        end
        default:
        begin
          st_r <= bsc_pkg::BSC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin drive, all strobes active low
  // ==========================================================
  logic in_start;
  logic data_beat;

  always_comb
  begin
    in_start = st_r == bsc_pkg::BSC_START;
    // a processor-started write carries no data in its strobe cycle
    data_beat = we_r & ((in_start & ~START_BY_PROC) | (st_r == bsc_pkg::BSC_HOLD) |
      (st_r == bsc_pkg::BSC_BEAT));
    bus.addr = addr_r;
    bus.proc_addr_strobe_n = ~(in_start & START_BY_PROC);
    bus.ctrl_addr_strobe_n = ~(in_start & ~START_BY_PROC);
    bus.chip_en_n = ~in_start;
    bus.burst_advance_n = ~(st_r == bsc_pkg::BSC_BEAT);
    bus.low_byte_write_n = ~(data_beat & lanes_r[0]);
    bus.high_byte_write_n = ~(data_beat & lanes_r[1]);
    bus.dq_host_oe = data_beat;
  end

  assign bus.dq_host_o = dq_r;

  // ==========================================================
  // read capture: data shows one cycle after each address cycle
  // ==========================================================
  logic rd_dly_r;
  logic [bsc_pkg::CNT_W-1:0] cap_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_dly_r <= 1'b0;
      cap_r <= bsc_pkg::CNT_RST;
      rd_line <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_dly_r <= ~we_r & (in_start | (st_r == bsc_pkg::BSC_BEAT));
      rd_valid <= st_r == bsc_pkg::BSC_DRAIN;
      if (req_ready)
      begin
        cap_r <= bsc_pkg::CNT_RST;
      end
      else if (rd_dly_r)
      begin
        rd_line[DW * 32'(cap_r) +: DW] <= bus.dq_bus;
        cap_r <= cap_r + 2'h1;
      end
    end
  end

endmodule // bsc_cache_ctrl
`default_nettype wire

// file: bsc_link_props.sv
// assertions on the controller to sram link
`timescale 1ns/1ps
`default_nettype none
module bsc_link_props (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link strobes
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_en_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  // data drivers
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe
);
  logic wr_any;
  logic wr_start;
  logic rd_start;

  assign wr_any = !low_byte_write_n || !high_byte_write_n;
  assign wr_start = !ctrl_addr_strobe_n && !chip_en_n && wr_any;
  assign rd_start = !ctrl_addr_strobe_n && !chip_en_n && !wr_any;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // properties
  // ==========================================================
  property p_strobe_pulse;
    $fell(ctrl_addr_strobe_n) |=> ctrl_addr_strobe_n;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("controller strobe held past one cycle");

  property p_ce_strobe;
    !chip_en_n |-> !ctrl_addr_strobe_n || !proc_addr_strobe_n;
  endproperty
  a_ce_strobe: assert property (p_ce_strobe)
    else $error("chip enable low outside a strobe cycle");

  property p_wr_data;
    wr_any |-> dq_host_oe && !dq_dev_oe;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write strobe without host data on the bus");

  property p_adv_beats;
    wr_start |=> !burst_advance_n [*3] ##1 burst_advance_n;
  endproperty
  a_adv_beats: assert property (p_adv_beats)
    else $error("advance not low for exactly three later beats");

  property p_wr_in_beat;
    wr_any |-> !ctrl_addr_strobe_n || !burst_advance_n;
  endproperty
  a_wr_in_beat: assert property (p_wr_in_beat)
    else $error("write strobe outside a burst beat");

  property p_lanes_hold;
    wr_start |=> $stable({low_byte_write_n, high_byte_write_n}) [*3];
  endproperty
  a_lanes_hold: assert property (p_lanes_hold)
    else $error("lane strobes changed inside a burst");

  property p_read_oe;
    rd_start |=> dq_dev_oe [*4];
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("sram did not drive four read beats");

  property p_adv_quiet;
    !burst_advance_n |-> ctrl_addr_strobe_n && proc_addr_strobe_n;
  endproperty
  a_adv_quiet: assert property (p_adv_quiet)
    else $error("advance together with an address strobe");

  c_write: cover property (wr_start);
  c_read: cover property (rd_start);
  c_low_lane: cover property (wr_start && high_byte_write_n);
endmodule // bsc_link_props
`default_nettype wire

// file: burst_sram_write_cache_ctrl_bench.sv
// self-checking bench for the controller and sram pair
`timescale 1ns/1ps
`default_nettype none
module burst_sram_write_cache_ctrl_bench;
  localparam logic [71:0] W1 = {18'h3C0F3, 18'h2A5A5, 18'h1F00F, 18'h0C3C3};
  localparam logic [71:0] W2 = {18'h12345, 18'h2BCDE, 18'h3F0F0, 18'h00F0F};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid_a = 1'b0;
  logic req_valid_b = 1'b0;
  logic req_write = 1'b0;
  logic [bsc_pkg::ADDR_W-1:0] req_addr = '0;
  logic [1:0] req_lanes = '0;
  logic [bsc_pkg::LINE_W-1:0] req_wline = '0;
  logic [9:0] req_tag = '0;
  logic ready_a, ready_b, rdv_a, rdv_b, hit_a, hit_b;
  logic [bsc_pkg::LINE_W-1:0] line_a, line_b;
  logic oe_n_b = 1'b0;
  logic act_a, act_b;
  logic [1:0] bidx_a, bidx_b;
  logic [71:0] e;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #2.5 mclk = ~mclk;

  // ==========================================================
  // pair a: controller strobe start, checked on the wire
  // ==========================================================
  bsc_if link_a();
  bsc_sram_dev i_bsc_sram_dev (.mclk(mclk), .resetn(resetn), .bus(link_a.dev),
    .out_en_n(1'b0), .burst_active(act_a), .beat_index(bidx_a));
  bsc_cache_ctrl i_bsc_cache_ctrl (.mclk(mclk), .resetn(resetn), .bus(link_a.host),
    .req_valid(req_valid_a), .req_ready(ready_a), .req_write(req_write),
    .req_addr(req_addr), .req_lanes(req_lanes), .req_wline(req_wline),
    .req_tag(req_tag[7:0]), .rd_line(line_a), .rd_valid(rdv_a), .tag_hit(hit_a));
  bsc_link_props i_bsc_link_props (.mclk(mclk), .resetn(resetn),
    .proc_addr_strobe_n(link_a.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(link_a.ctrl_addr_strobe_n),
    .burst_advance_n(link_a.burst_advance_n), .chip_en_n(link_a.chip_en_n),
    .low_byte_write_n(link_a.low_byte_write_n),
    .high_byte_write_n(link_a.high_byte_write_n),
    .dq_host_oe(link_a.dq_host_oe), .dq_dev_oe(link_a.dq_dev_oe));

  // ==========================================================
  // pair b: processor strobe start, slow tag, 10-bit tags
  // ==========================================================
  bsc_if link_b();
  bsc_sram_dev i_bsc_sram_dev_b (.mclk(mclk), .resetn(resetn), .bus(link_b.dev),
    .out_en_n(oe_n_b), .burst_active(act_b), .beat_index(bidx_b));
  bsc_cache_ctrl #(.LINES_PER_SECTOR(4), .TAG_W(10), .SLOW_TAG(1'b1),
    .START_BY_PROC(1'b1)) i_bsc_cache_ctrl_b (.mclk(mclk), .resetn(resetn),
    .bus(link_b.host), .req_valid(req_valid_b), .req_ready(ready_b),
    .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
    .req_wline(req_wline), .req_tag(req_tag), .rd_line(line_b), .rd_valid(rdv_b),
    .tag_hit(hit_b));

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one line request; lat < 0 skips the latency figure
  task automatic op(input bit b, input logic w, input logic [15:0] a,
    input logic [1:0] ln, input logic [71:0] d, input logic [9:0] t, input int lat);
    int n;
    @(negedge mclk);
    req_write = w;
    req_addr = a;
    req_lanes = ln;
    req_wline = d;
    req_tag = t;
    req_valid_a = !b;
    req_valid_b = b;
    @(negedge mclk);
    req_valid_a = 1'b0;
    req_valid_b = 1'b0;
    n = 1;
    while (n < 40 && (w ? (b ? ready_b : ready_a) : (b ? rdv_b : rdv_a)) !== 1'b1)
    begin
      @(negedge mclk);
      n++;
    end
    if (lat >= 0)
      chk(n, lat);
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_interleave();
    op(1'b0, 1'b1, 16'h0122, 2'h3, W1, 10'h05A, 5);
    chk({act_a, bidx_a}, 72'h7);
    op(1'b0, 1'b0, 16'h0120, 2'h0, '0, 10'h05A, 6);
    for (int k = 0; k < 4; k++)
      e[18*k +: 18] = W1[18*(k^2) +: 18];
    chk(line_a, e);
    chk(hit_a, 72'h1);
    $display("t_interleave finished");
  endtask

  // low lane only must leave the upper nine bits untouched
  task automatic t_lanes();
    op(1'b0, 1'b1, 16'h0120, 2'h1, W2, 10'h05B, 5);
    chk(hit_a, 72'h0);
    op(1'b0, 1'b0, 16'h0120, 2'h0, '0, 10'h05B, 6);
    for (int k = 0; k < 4; k++)
      e[18*k +: 18] = {W1[18*(k^2)+9 +: 9], W2[18*k +: 9]};
    chk(line_a, e);
    chk(hit_a, 72'h1);
    $display("t_lanes finished");
  endtask

  task automatic t_proc_slow();
    op(1'b1, 1'b1, 16'h0307, 2'h3, W2, 10'h3FF, 7);
    chk({act_b, bidx_b}, 72'h7);
    op(1'b1, 1'b0, 16'h0304, 2'h0, '0, 10'h3FF, 7);
    for (int k = 0; k < 4; k++)
      e[18*k +: 18] = W2[18*(k^3) +: 18];
    chk(line_b, e);
    chk(hit_b, 72'h1);
    // sram outputs held off: the line must come back empty
    oe_n_b = 1'b1;
    op(1'b1, 1'b0, 16'h0304, 2'h0, '0, 10'h3FF, 7);
    chk(line_b, 72'h0);
    oe_n_b = 1'b0;
    $display("t_proc_slow finished");
  endtask

  // ==========================================================
  // run and hang guard
  // ==========================================================
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    t_interleave();
    t_lanes();
    t_proc_slow();
    close_out();
  end
endmodule // burst_sram_write_cache_ctrl_bench
`default_nettype wire
